// *** tslr_pkg.sv ***
// Package for the trigger sequencer limit register block.
package tslr_pkg;
    localparam int unsigned TSLR_AW = 4;
    localparam logic [TSLR_AW-1:0] TSLR_OFF_STEP_DELAY = 4'h0;
    localparam logic [TSLR_AW-1:0] TSLR_OFF_LOOP_LIMIT = 4'h4;
    localparam logic [TSLR_AW-1:0] TSLR_OFF_CONTROL = 4'h8;
    localparam logic [15:0] TSLR_LIMIT_RESET = 16'h0000;
    localparam logic [15:0] TSLR_BASE_DELAY = 16'h0001;
    localparam int unsigned TSLR_CTL_EN_BIT = 0;
    localparam int unsigned TSLR_CTL_START_BIT = 1;
    localparam int unsigned TSLR_CTL_LOCK_BIT = 2;
    localparam logic [1:0] TSLR_RESP_OKAY = 2'b00;
    localparam logic [1:0] TSLR_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic sequencer_enable;
        logic sequence_start_bit;
    } tslr_ctrl_t;

    typedef struct packed {
        logic [16:0] effective_step_delay;
        logic [15:0] loop_count_limit_zero;
        logic locked;
    } tslr_out_t;
endpackage

// *** tslr_regs.sv ***
// Limit registers of the trigger sequencer behind an AXI4-Lite slave.
//
// Functional notes
// - A 16-bit step delay value sets the extra sequencer clocks per step.
// - The effective step delay is the stored value plus one base clock.
// - The step delay register cannot be written while enable and start are set.
// - The counter 0 limit serves as jump loop count or counter 0 terminal value.
// - The counter 0 limit cannot be written while the sequencer runs steps.
`timescale 1ns/100ps
module tslr_regs
    import tslr_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [TSLR_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [TSLR_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Values handed to the sequencer.
    output tslr_out_t seq_out
);
    logic [TSLR_AW-1:0] aw_q;
    logic aw_have_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic w_have_q;
    logic [15:0] step_delay_q;
    logic [15:0] loop_limit_q;
    tslr_ctrl_t ctrl_q;
    logic locked;
    logic do_write;
    logic [1:0] bresp_q;
    logic bvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;

    // Both limits share one lock: the sequencer is running step commands.
    assign locked = ctrl_q.sequencer_enable & ctrl_q.sequence_start_bit;
    assign do_write = aw_have_q & w_have_q & ~bvalid_q;

    // Address and data are accepted independently and held until the write.
    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready = ~w_have_q;
    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wd_q <= '0;
            ws_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    // Register updates; locked limits keep their value and answer SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_delay_q <= TSLR_LIMIT_RESET;
            loop_limit_q <= TSLR_LIMIT_RESET;
            ctrl_q <= '0;
            bresp_q <= TSLR_RESP_OKAY;
        end else if (do_write) begin
            bresp_q <= TSLR_RESP_OKAY;
            if (aw_q == TSLR_OFF_STEP_DELAY) begin
                if (locked) begin
                    bresp_q <= TSLR_RESP_SLVERR;
                end else begin
                    if (ws_q[0]) step_delay_q[7:0] <= wd_q[7:0];
                    if (ws_q[1]) step_delay_q[15:8] <= wd_q[15:8];
                end
            end else if (aw_q == TSLR_OFF_LOOP_LIMIT) begin
                if (locked) begin
                    bresp_q <= TSLR_RESP_SLVERR;
                end else begin
                    if (ws_q[0]) loop_limit_q[7:0] <= wd_q[7:0];
                    if (ws_q[1]) loop_limit_q[15:8] <= wd_q[15:8];
                end
            end else if (aw_q == TSLR_OFF_CONTROL) begin
                if (ws_q[0]) begin
                    ctrl_q.sequencer_enable <= wd_q[TSLR_CTL_EN_BIT];
                    ctrl_q.sequence_start_bit <= wd_q[TSLR_CTL_START_BIT];
                end
            end else begin
                bresp_q <= TSLR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Reads always succeed on the limits, locked or not.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= TSLR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= TSLR_RESP_OKAY;
            rdata_q <= '0;
            if (s_axi_araddr == TSLR_OFF_STEP_DELAY) begin
                rdata_q[15:0] <= step_delay_q;
            end else if (s_axi_araddr == TSLR_OFF_LOOP_LIMIT) begin
                rdata_q[15:0] <= loop_limit_q;
            end else if (s_axi_araddr == TSLR_OFF_CONTROL) begin
                rdata_q[TSLR_CTL_EN_BIT] <= ctrl_q.sequencer_enable;
                rdata_q[TSLR_CTL_START_BIT] <= ctrl_q.sequence_start_bit;
                rdata_q[TSLR_CTL_LOCK_BIT] <= locked;
            end else begin
                rresp_q <= TSLR_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // The base clock is added here so the sequencer counts the full delay.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_out <= '0;
        end else begin
            seq_out.effective_step_delay <=
                {1'b0, step_delay_q} + {1'b0, TSLR_BASE_DELAY};
            seq_out.loop_count_limit_zero <= loop_limit_q;
            seq_out.locked <= locked;
        end
    end
endmodule

// *** tslr_regs_properties.sv ***
// Checker of the sequencer values that the limit registers drive.
`timescale 1ns/100ps
module tslr_regs_chk
    import tslr_pkg::*;
(
    // Clock, reset and watched outputs.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire tslr_out_t seq_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_base_delay: assert property (
        $past(aresetn) |-> seq_out.effective_step_delay != 17'h0_0000)
        else $error("step delay lacks base clock");
    chk_delay_range: assert property (
        seq_out.effective_step_delay <= 17'h1_0000)
        else $error("step delay out of range");
    chk_delay_frozen: assert property (
        seq_out.locked && $past(seq_out.locked)
        |-> $stable(seq_out.effective_step_delay))
        else $error("step delay moved while locked");
    chk_limit_frozen: assert property (
        seq_out.locked && $past(seq_out.locked)
        |-> $stable(seq_out.loop_count_limit_zero))
        else $error("loop limit moved while locked");
    // Both fields move one edge after the write response rises.
    chk_limit_source: assert property (
        $changed(seq_out.loop_count_limit_zero) && $past(aresetn)
        |-> $past(s_axi_bvalid))
        else $error("loop limit moved without a write");
    chk_delay_source: assert property (
        $changed(seq_out.effective_step_delay) && $past(aresetn, 2)
        |-> $past(s_axi_bvalid))
        else $error("step delay moved without a write");
endmodule
bind tslr_regs tslr_regs_chk chk_u (.aclk, .aresetn, .s_axi_bvalid, .seq_out);

// *** test_trigger_sequencer_limit_regs.sv ***
// Self-checking bench of the limit register block.
`timescale 1ns/100ps
module test_trigger_sequencer_limit_regs import tslr_pkg::*;;
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
logic s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [TSLR_AW-1:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, r;
tslr_out_t seq_out;
logic [31:0] seed = 32'h00d1_6ba8;
int num_errors, compares, cyc;
tslr_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .seq_out);
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
function automatic logic [31:0] lim(input logic [31:0] x);
    return {16'h0000, x[15:0]};
endfunction
task automatic ck(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", n, e, s);
    end
endtask
// Handshakes are judged at the rising edge itself, on the values that stand
// before the edge, and each request is released only once it was taken.
task automatic wr(input logic [3:0] a, input logic [31:0] x);
    logic b;
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        b = s_axi_bvalid;
        r = s_axi_bresp;
    end while (!b);
endtask
task automatic rd(input logic [3:0] a);
    logic rv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        rv = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
    end while (!rv);
endtask
task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
end
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        num_errors++;
        print_verdict();
    end
end
initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TSLR_OFF_LOOP_LIMIT);
    ck("limit reset", 32'h0000_0000, d);
    for (int i = 0; i < 8; i++) begin
        v = (i == 0) ? 32'hffff_ffff : rnd();
        wr(TSLR_OFF_CONTROL, 32'h0000_0001);
        wr(TSLR_OFF_STEP_DELAY, v);
        ck("delay resp", 32'(TSLR_RESP_OKAY), 32'(r));
        wr(TSLR_OFF_LOOP_LIMIT, ~v);
        rd(TSLR_OFF_STEP_DELAY);
        ck("delay", lim(v), d);
        ck("eff", lim(v) + 1, 32'(seq_out.effective_step_delay));
        ck("loop", lim(~v), 32'(seq_out.loop_count_limit_zero));
        wr(TSLR_OFF_CONTROL, 32'h0000_0003);
        wr(TSLR_OFF_STEP_DELAY, rnd());
        ck("locked resp", 32'(TSLR_RESP_SLVERR), 32'(r));
        wr(TSLR_OFF_LOOP_LIMIT, rnd());
        ck("locked resp", 32'(TSLR_RESP_SLVERR), 32'(r));
        rd(TSLR_OFF_STEP_DELAY);
        ck("kept delay", lim(v), d);
        rd(TSLR_OFF_LOOP_LIMIT);
        ck("kept loop", lim(~v), d);
        ck("locked out", 32'h0000_0001, 32'(seq_out.locked));
        rd(TSLR_OFF_CONTROL);
        ck("control", 32'h0000_0007, d);
    end
    wr(4'hc, rnd());
    ck("unmapped resp", 32'(TSLR_RESP_SLVERR), 32'(r));
    rd(4'hc);
    ck("unmapped data", 32'h0000_0000, d);
    print_verdict();
end
endmodule
